// [pkg/qslu_defs.svh]
`ifndef QSLU_DEFS_SVH
`define QSLU_DEFS_SVH

// Per-line register block: line n sits at n * stride
`define QSLU_OFF_CFG 4'h0
`define QSLU_OFF_TX 4'h4
`define QSLU_OFF_RX 4'h8
`define QSLU_OFF_STAT 4'hc
`define QSLU_MODEM_CTRL 8'h40
`define QSLU_MODEM_STAT 8'h44
`define QSLU_DEVCODE 8'h48

// Reset: 9600 baud, two stop bits, no parity, 8 data bits
`define QSLU_CFG_RESET 9'h04e
`define QSLU_BAUD_DEFAULT 4'he
`define QSLU_DEVCODE_RESET 6'h20
`define QSLU_MCTL_RESET 4'h0

// Sixteen baud ticks per bit
`define QSLU_OVERSAMPLE 16
`define QSLU_MID_TICK 6'd7
`define QSLU_LAST_TICK 6'd15
`define QSLU_STOP1_TICKS 6'd16
`define QSLU_STOP15_TICKS 6'd24
`define QSLU_STOP2_TICKS 6'd32
`define QSLU_MAX_BITS 4'd8
`define QSLU_SHORT_BITS 4'd5

`define QSLU_RESP_OKAY 2'b00
`define QSLU_RESP_SLVERR 2'b10

`endif

// [pkg/qslu_pkg.sv]
package qslu_pkg;

  typedef struct packed {
    logic parity_odd;
    logic parity_en;
    logic stop_count_select;
    logic char_len_select_b;
    logic char_len_select_a;
    logic [3:0] baud_sel;
  } qslu_cfg_t;

  typedef struct packed {
    logic overrun;
    logic framing_err;
    logic parity_err;
    logic valid;
    logic [7:0] data;
  } qslu_rx_t;

  typedef struct packed {
    logic ring;
    logic sec_rx;
    logic cts;
    logic carrier;
  } qslu_modem_in_t;

  typedef struct packed {
    logic speed_sel;
    logic sec_tx;
    logic rts;
    logic dtr;
  } qslu_modem_ctl_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } qslu_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } qslu_rx_state_t;

endpackage

// [src/qslu_top.sv]
// Operation
// - Four independent serial lines, each with own transmitter and receiver.
// - Per-line rate from fifteen baud choices, 50 through 9600.
// - Transmitter and receiver of a line share one baud tick.
// - Transmitter sends one or two stop bits per line setting.
// - Five-bit characters with two-stop setting get 1.5 stop bits.
// - Optional parity, even or odd; generated on send, checked on receive.
// - Unit answers an even device code and the odd code after it.
// - Two length selects give 5, 6 or 7 data bits.
// - Both length selects clear gives 8 data bits, the default.
// - Lines 0 to 2 hold ready and request-to-send asserted.
// - Line 3 flags modem input changes, has programmable modem outputs.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "qslu_defs.svh"

module qslu_top import qslu_pkg::*; #(
  parameter int CLK_HZ = 40_000_000,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] rxd,
  output logic [3:0] txd,
  output logic [3:0] dtr,
  output logic [3:0] rts,
  input wire qslu_modem_in_t modem_in,
  output logic sec_tx,
  output logic speed_sel,
  output logic modem_change,
  input wire logic [5:0] io_dev_sel,
  output logic io_dev_hit
);

  localparam int LINES = 4;

  qslu_cfg_t cfg [LINES];
  qslu_rx_t rxs [LINES];
  logic [LINES-1:0] tx_busy;
  logic [LINES-1:0] tick;
  logic [LINES-1:0] rx_done;
  logic [LINES-1:0] rd_clr;

  qslu_modem_ctl_t mctl;
  qslu_modem_in_t ms1, ms2, mprev;
  logic [3:0] mchg;
  logic [5:0] dev_code;

  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic aw_take, w_take, wr_fire, ar_take, next_rvalid;
  logic wr_lines, rd_lines, wr_hit, rd_hit;
  logic [31:0] rd_val;

  function automatic logic [15:0] div_of(input logic [3:0] s);
    int b;
    case (s)
      4'h0: b = 500;
      4'h1: b = 750;
      4'h2: b = 1100;
      4'h3: b = 1345;
      4'h4: b = 1500;
      4'h5: b = 3000;
      4'h6: b = 6000;
      4'h7: b = 12000;
      4'h8: b = 18000;
      4'h9: b = 20000;
      4'ha: b = 24000;
      4'hb: b = 36000;
      4'hc: b = 48000;
      4'hd: b = 72000;
      default: b = 96000;
    endcase
    // Rates kept in tenths of baud so 134.5 stays exact
    div_of = 16'((CLK_HZ * 10) / (b * `QSLU_OVERSAMPLE));
  endfunction

  // AXI4-Lite write path; address and data may arrive in either order
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_lines = aw_addr[ADDR_W-1:6] == '0;
  assign rd_lines = s_axi_araddr[ADDR_W-1:6] == '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end else begin
      s_axi_awready <= ~aw_held;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_lane0 <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_wready <= ~w_held;
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    if (wr_lines) begin
      wr_hit = 1'b1;
    end else if (aw_addr == ADDR_W'(`QSLU_MODEM_CTRL) ||
                 aw_addr == ADDR_W'(`QSLU_MODEM_STAT) ||
                 aw_addr == ADDR_W'(`QSLU_DEVCODE)) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `QSLU_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `QSLU_RESP_OKAY : `QSLU_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read path
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (rd_lines) begin
      case (s_axi_araddr[3:0])
        `QSLU_OFF_CFG: rd_val = {23'h0, cfg[s_axi_araddr[5:4]]};
        `QSLU_OFF_TX: rd_val = '0;
        `QSLU_OFF_RX: rd_val = {20'h0, rxs[s_axi_araddr[5:4]]};
        `QSLU_OFF_STAT: rd_val = {30'h0, rxs[s_axi_araddr[5:4]].valid,
                                  tx_busy[s_axi_araddr[5:4]]};
        default: rd_hit = 1'b0;
      endcase
    end else begin
      case (s_axi_araddr)
        ADDR_W'(`QSLU_MODEM_CTRL): rd_val = {28'h0, mctl};
        ADDR_W'(`QSLU_MODEM_STAT): rd_val = {24'h0, mchg, ms2};
        ADDR_W'(`QSLU_DEVCODE): rd_val = {26'h0, dev_code};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `QSLU_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `QSLU_RESP_OKAY : `QSLU_RESP_SLVERR;
      end
    end
  end

  for (genvar i = 0; i < LINES; i++) begin : g_line
    logic [15:0] bcnt;
    logic [3:0] nb;
    logic [5:0] stop_len;
    logic [7:0] tmask;
    logic sel_w, tx_go;
    qslu_tx_state_t ts;
    logic [5:0] tt;
    logic [3:0] tb;
    logic [7:0] tsh;
    logic tpar;
    qslu_rx_state_t rs;
    logic [5:0] rt;
    logic [3:0] rb;
    logic [7:0] rsh;
    logic rpe, rs1, rs2;

    assign nb = `QSLU_MAX_BITS - {2'b00, cfg[i].char_len_select_b,
                                  cfg[i].char_len_select_a};
    assign tmask = 8'hff >> (`QSLU_MAX_BITS - nb);
    assign stop_len = !cfg[i].stop_count_select ? `QSLU_STOP1_TICKS :
                      (nb == `QSLU_SHORT_BITS) ? `QSLU_STOP15_TICKS :
                      `QSLU_STOP2_TICKS;
    assign sel_w = wr_fire & w_lane0 & wr_lines & (aw_addr[5:4] == 2'(i));
    assign tx_go = sel_w & (aw_addr[3:0] == `QSLU_OFF_TX) & (ts == TX_IDLE);
    assign tx_busy[i] = ts != TX_IDLE;
    assign rd_clr[i] = ar_take & rd_lines &
                       (s_axi_araddr[5:4] == 2'(i)) &
                       (s_axi_araddr[3:0] == `QSLU_OFF_RX);
    assign rx_done[i] = (rs == RX_STOP) & tick[i] & (rt == `QSLU_LAST_TICK);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg[i] <= `QSLU_CFG_RESET;
      end else if (sel_w && aw_addr[3:0] == `QSLU_OFF_CFG) begin
        cfg[i] <= qslu_cfg_t'(w_data[8:0]);
      end
    end

    // One tick drives both directions of the line
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        bcnt <= '0;
        tick[i] <= 1'b0;
      end else if (bcnt == '0) begin
        bcnt <= div_of(cfg[i].baud_sel) - 16'd1;
        tick[i] <= 1'b1;
      end else begin
        bcnt <= bcnt - 16'd1;
        tick[i] <= 1'b0;
      end
    end

    // Writes to a busy transmitter are dropped; software polls busy
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ts <= TX_IDLE;
        txd[i] <= 1'b1;
        tt <= '0;
        tb <= '0;
        tsh <= '0;
        tpar <= 1'b0;
      end else begin
        case (ts)
          TX_IDLE: if (tx_go) begin
            tsh <= w_data[7:0] & tmask;
            tpar <= ^(w_data[7:0] & tmask) ^ cfg[i].parity_odd;
            txd[i] <= 1'b0;
            tt <= '0;
            ts <= TX_START;
          end
          TX_START: if (tick[i]) begin
            tt <= tt + 6'd1;
            if (tt == `QSLU_LAST_TICK) begin
              tt <= '0;
              tb <= '0;
              txd[i] <= tsh[0];
              ts <= TX_DATA;
            end
          end
          TX_DATA: if (tick[i]) begin
            tt <= tt + 6'd1;
            if (tt == `QSLU_LAST_TICK) begin
              tt <= '0;
              if (tb == nb - 4'd1) begin
                txd[i] <= cfg[i].parity_en ? tpar : 1'b1;
                ts <= cfg[i].parity_en ? TX_PAR : TX_STOP;
              end else begin
                tb <= tb + 4'd1;
                tsh <= tsh >> 1;
                txd[i] <= tsh[1];
              end
            end
          end
          TX_PAR: if (tick[i]) begin
            tt <= tt + 6'd1;
            if (tt == `QSLU_LAST_TICK) begin
              tt <= '0;
              txd[i] <= 1'b1;
              ts <= TX_STOP;
            end
          end
          TX_STOP: if (tick[i]) begin
            tt <= tt + 6'd1;
            if (tt == stop_len - 6'd1) begin
              ts <= TX_IDLE;
            end
          end
          default: ts <= TX_IDLE;
        endcase
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rs1 <= 1'b1;
        rs2 <= 1'b1;
      end else begin
        rs1 <= rxd[i];
        rs2 <= rs1;
      end
    end

    // Start bit must still be low at mid-bit, else it was a glitch
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rs <= RX_IDLE;
        rt <= '0;
        rb <= '0;
        rsh <= '0;
        rpe <= 1'b0;
      end else if (tick[i]) begin
        rt <= rt + 6'd1;
        case (rs)
          RX_IDLE: if (!rs2) begin
            rt <= '0;
            rs <= RX_START;
          end
          RX_START: if (rt == `QSLU_MID_TICK) begin
            rt <= '0;
            rb <= '0;
            rsh <= '0;
            rpe <= cfg[i].parity_odd;
            rs <= rs2 ? RX_IDLE : RX_DATA;
          end
          RX_DATA: if (rt == `QSLU_LAST_TICK) begin
            rt <= '0;
            rsh[rb[2:0]] <= rs2;
            rpe <= rpe ^ rs2;
            rb <= rb + 4'd1;
            if (rb == nb - 4'd1) begin
              rs <= cfg[i].parity_en ? RX_PAR : RX_STOP;
            end
          end
          RX_PAR: if (rt == `QSLU_LAST_TICK) begin
            rt <= '0;
            rpe <= rpe ^ rs2;
            rs <= RX_STOP;
          end
          RX_STOP: if (rt == `QSLU_LAST_TICK) begin
            rs <= RX_IDLE;
          end
          default: rs <= RX_IDLE;
        endcase
      end
    end

    // New character beats a clearing read in the same cycle
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rxs[i] <= '0;
      end else if (rx_done[i]) begin
        rxs[i].data <= rsh;
        rxs[i].valid <= 1'b1;
        rxs[i].parity_err <= cfg[i].parity_en & rpe;
        rxs[i].framing_err <= ~rs2;
        rxs[i].overrun <= rxs[i].valid & ~rd_clr[i];
      end else if (rd_clr[i]) begin
        rxs[i].valid <= 1'b0;
        rxs[i].overrun <= 1'b0;
      end
    end
  end

  // Line 3 modem control and change detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mctl <= `QSLU_MCTL_RESET;
    end else if (wr_fire && w_lane0 &&
                 aw_addr == ADDR_W'(`QSLU_MODEM_CTRL)) begin
      mctl <= qslu_modem_ctl_t'(w_data[3:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms1 <= '0;
      ms2 <= '0;
      mprev <= '0;
    end else begin
      ms1 <= modem_in;
      ms2 <= ms1;
      mprev <= ms2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mchg <= '0;
      modem_change <= 1'b0;
    end else begin
      // Change sets win over write-one-to-clear
      if (wr_fire && w_lane0 && aw_addr == ADDR_W'(`QSLU_MODEM_STAT)) begin
        mchg <= (mchg & ~w_data[7:4]) | (ms2 ^ mprev);
      end else begin
        mchg <= mchg | (ms2 ^ mprev);
      end
      modem_change <= |mchg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dtr <= '0;
      rts <= '0;
      sec_tx <= 1'b0;
      speed_sel <= 1'b0;
    end else begin
      dtr <= {mctl.dtr, 3'b111};
      rts <= {mctl.rts, 3'b111};
      sec_tx <= mctl.sec_tx;
      speed_sel <= mctl.speed_sel;
    end
  end

  // Low bit forced to zero so the pair is always even, even plus one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_code <= `QSLU_DEVCODE_RESET;
      io_dev_hit <= 1'b0;
    end else begin
      if (wr_fire && w_lane0 && aw_addr == ADDR_W'(`QSLU_DEVCODE)) begin
        dev_code <= {w_data[5:1], 1'b0};
      end
      io_dev_hit <= io_dev_sel[5:1] == dev_code[5:1];
    end
  end

endmodule

// [bench/qslu_chk.sv]
`timescale 1ns/1ps
module qslu_chk import qslu_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] txd,
  input wire logic [3:0] dtr,
  input wire logic [3:0] rts,
  input wire qslu_modem_in_t modem_in,
  input wire logic modem_change
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  dtr_fixed_a: assert property (
    $past(aresetn) |-> dtr[2:0] == 3'h7 && rts[2:0] == 3'h7)
    else $error("fixed modem outputs dropped");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read answer");
  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  start_len_a: assert property ($fell(txd[0]) |=> !txd[0] [*8])
    else $error("start bit too short");
  modem_chg_a: assert property (
    modem_in != $past(modem_in) |-> ##[1:6] modem_change)
    else $error("modem change not flagged");
endmodule

bind qslu_top qslu_chk i_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txd, .dtr, .rts,
  .modem_in, .modem_change);

// [bench/qslu_term.sv]
`timescale 1ns/1ps
module qslu_term (
  input wire logic aclk,
  input wire logic [3:0] txd_in,
  output logic [3:0] rxd_out
);
  longint t_fall;
  initial rxd_out = 4'hf; // Mark between frames
  // Mid-bit sampling timed from the start edge only
  task automatic grab(input int ln, n, bt, output logic [10:0] v);
    v = '0;
    wait (txd_in[ln] == 1'b0);
    t_fall = $time;
    for (int i = 0; i < n; i++) begin
      repeat (i == 0 ? bt / 2 : bt) @(posedge aclk);
      v[i] = txd_in[ln];
    end
  endtask
  task automatic send(input int ln, n, bt, input logic [10:0] f);
    for (int i = 0; i <= n; i++) begin
      rxd_out[ln] <= i < n ? f[i] : 1'b1;
      repeat (bt) @(posedge aclk);
    end
  endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam int CLK_HZ = 1_536_000;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sec_tx, speed_sel, modem_change, io_dev_hit;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, rxd, txd, dtr, rts;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [5:0] io_dev_sel;
  qslu_pkg::qslu_modem_in_t modem_in;
  int cycles, failures, compares;

  qslu_top #(.CLK_HZ(CLK_HZ)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd,
    .txd, .dtr, .rts, .modem_in, .sec_tx, .speed_sel, .modem_change,
    .io_dev_sel, .io_dev_hit);
  qslu_term i_term (.aclk, .txd_in(txd), .rxd_out(rxd));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic final_report;
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Budget covers all frames with margin
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    // Late ready exercises the response hold
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [10:0] frm(logic [7:0] v, int nb, pe,
                                      logic po, sv);
    logic [10:0] f;
    logic p;
    f = '0;
    p = po;
    for (int i = 0; i < nb; i++) begin
      f[i+1] = v[i];
      p ^= v[i];
    end
    if (pe != 0)
      f[nb+1] = p;
    f[nb+pe+1] = sv;
    return f;
  endfunction

  task automatic dev_scan(input int b);
    for (int k = b - 1; k < b + 3; k++) begin
      io_dev_sel <= 6'(k);
      repeat (2) @(posedge aclk);
      chk("dev hit", 32'(k == b || k == b + 1), 32'(io_dev_hit));
    end
  endtask

  // Mode 0 sends, 1 receives, 2 receives with bad parity
  task automatic run(input int ln, input logic [8:0] cfg,
                     input logic [7:0] v, input int mode,
                     input logic [31:0] e);
    int nb, pe, bt, n, t0, ex;
    logic [10:0] fr;
    logic [31:0] st;
    logic ok;
    nb = 8 - int'(cfg[5:4]);
    pe = int'(cfg[7]);
    bt = cfg[3:0] == 4'hc ? 320 : 160;
    n = nb + pe + 2;
    ex = ((n - 1) * 16 + (!cfg[6] ? 16 : nb == 5 ? 24 : 32)) * bt / 16;
    wr(8'(ln * 16), 32'(cfg));
    if (mode == 0) begin
      fork
        wr(8'(ln * 16 + 4), 32'(v));
        i_term.grab(ln, n, bt, fr);
      join
      chk("tx frame", 32'(frm(v, nb, pe, cfg[8], 1'b1)), 32'(fr));
      do rd(8'(ln * 16 + 12), st); while (st[0]);
      t0 = int'(($time - i_term.t_fall) / 25);
      ok = t0 > ex - bt / 8 - 8 && t0 < ex + bt / 8 + 8;
      chk("tx frame time", 32'h1, 32'(ok));
    end else begin
      fr = frm(v, nb, pe, cfg[8] ^ (mode == 2), 1'b1);
      i_term.send(ln, n, bt, fr);
      do rd(8'(ln * 16 + 12), st); while (!st[1]);
      rd(8'(ln * 16 + 8), st);
      chk("rx word", e, st);
      rd(8'(ln * 16 + 8), st);
      chk("rx valid clear", 32'h0, 32'(st[8]));
    end
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    io_dev_sel = 6'h00;
    modem_in = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("txd idle", 32'hf, 32'(txd));
    chk("dtr", 32'h7, 32'(dtr));
    chk("rts", 32'h7, 32'(rts));
    rd(8'h00, d);
    chk("cfg reset", 32'h04e, d);
    rd(8'h4c, d);
    chk("unmapped resp", 32'h2, 32'(resp));
    wr(8'h4c, 32'h0);
    chk("unmapped wr resp", 32'h2, 32'(resp));
    dev_scan(32);
    wr(8'h48, 32'h15);
    rd(8'h48, d);
    chk("devcode", 32'h14, d);
    dev_scan(20);
    wr(8'h40, 32'hf);
    chk("modem ctrl resp", 32'h0, 32'(resp));
    // Outputs follow the control register one cycle later
    repeat (2) @(posedge aclk);
    chk("line3 outs", 32'h3ff, 32'({dtr, rts, sec_tx, speed_sel}));
    modem_in <= 4'h2;
    repeat (8) @(posedge aclk);
    chk("modem change", 32'h1, 32'(modem_change));
    rd(8'h44, d);
    chk("modem stat", 32'h22, d);
    wr(8'h44, 32'h20);
    repeat (3) @(posedge aclk);
    chk("modem cleared", 32'h0, 32'(modem_change));
    run(0, 9'h04e, 8'ha5, 0, 0);
    run(1, 9'h0fe, 8'h1b, 0, 0);
    run(2, 9'h19c, 8'hc3, 0, 0);
    run(3, 9'h06e, 8'h2d, 0, 0);
    run(0, 9'h03e, 8'h15, 0, 0);
    run(2, 9'h19c, 8'h5a, 1, 32'h15a);
    run(2, 9'h19c, 8'h33, 2, 32'h333);
    run(0, 9'h04e, 8'he7, 1, 32'h1e7);
    run(1, 9'h0fe, 8'hff, 1, 32'h11f);
    final_report();
  end
endmodule
